// file: tm8_pkg.sv
// Purpose: constants and types for the 8-bit timer register block
// Assumes: Avalon-MM word registers, byte address = 4 * index
// Notes: register indices, control and status bit positions and prescaler masks
package tm8_pkg;
    localparam logic [5:0] IDX_CTRL_A = 6'h24;
    localparam logic [5:0] IDX_CTRL_B = 6'h25;
    localparam logic [5:0] IDX_COUNT  = 6'h26;
    localparam logic [5:0] IDX_CMP_A  = 6'h27;
    localparam logic [5:0] IDX_CMP_B  = 6'h28;
    localparam logic [5:0] IDX_MASK   = 6'h2e;
    localparam logic [5:0] IDX_FLAGS  = 6'h15;
    localparam int BIT_FORCE_A = 7;
    localparam int BIT_FORCE_B = 6;
    localparam int BIT_WM2     = 3;
    localparam int BIT_CMPB    = 2;
    localparam int BIT_CMPA    = 1;
    localparam int BIT_OVF     = 0;
    localparam logic [7:0] RST_VAL  = 8'h00;
    localparam logic [7:0] CNT_MAX  = 8'hff;
    localparam logic [7:0] CNT_BOT  = 8'h00;
    localparam logic [9:0] DIV8_M   = 10'h007;
    localparam logic [9:0] DIV64_M  = 10'h03f;
    localparam logic [9:0] DIV256_M = 10'h0ff;
    localparam logic [9:0] DIV1K_M  = 10'h3ff;
    typedef enum logic [2:0] {
        CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011, CS_DIV256 = 3'b100, CS_DIV1K = 3'b101,
        CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
    } tm8_cs_t;
    typedef enum logic [2:0] {
        WM_NORMAL = 3'b000, WM_PC_FF = 3'b001, WM_CTC = 3'b010,
        WM_FAST_FF = 3'b011, WM_RSV4 = 3'b100, WM_PC_OCA = 3'b101,
        WM_RSV6 = 3'b110, WM_FAST_OCA = 3'b111
    } tm8_wm_t;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } tm8_av_req_t;
endpackage

// file: tm8_tick_gen.sv
// Purpose: timer clock enable from prescaler or external pin
// Assumes: pin is synchronous-sampled through two flops
// Notes: tick is one core_clk cycle wide, except in divide by 1 where it stays high every cycle
`timescale 1ns/1ps
module tm8_tick_gen #(
    parameter int PRE_W = 10
) (
    input  wire logic           core_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           ce_i,
    input  wire tm8_pkg::tm8_cs_t cs_i,
    input  wire logic           pin_i,
    output logic                tick_o
);
    logic [PRE_W-1:0] pre_r;
    logic             s1_r;
    logic             s2_r;
    logic             s3_r;
    wire  logic       pin_fall;
    wire  logic       pin_rise;
    wire  logic [9:0] low10;

    if (PRE_W < 10) begin : g_chk
        $error("PRE_W below 10 cannot reach divide by 1024");
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pre_r <= '0;
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
        end else if (ce_i) begin
            pre_r <= pre_r + 1'b1;
            s1_r  <= pin_i;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
        end
    end

    assign low10    = pre_r[9:0];
    assign pin_fall = s3_r & ~s2_r;
    assign pin_rise = s2_r & ~s3_r;

    always_comb begin
        case (cs_i)
            tm8_pkg::CS_DIV1:     tick_o = 1'b1;
            tm8_pkg::CS_DIV8:     tick_o = (low10 & tm8_pkg::DIV8_M) == tm8_pkg::DIV8_M;
            tm8_pkg::CS_DIV64:    tick_o = (low10 & tm8_pkg::DIV64_M) == tm8_pkg::DIV64_M;
            tm8_pkg::CS_DIV256:   tick_o = (low10 & tm8_pkg::DIV256_M) == tm8_pkg::DIV256_M;
            tm8_pkg::CS_DIV1K:    tick_o = low10 == tm8_pkg::DIV1K_M;
            tm8_pkg::CS_EXT_FALL: tick_o = pin_fall;
            tm8_pkg::CS_EXT_RISE: tick_o = pin_rise;
            default:              tick_o = 1'b0;
        endcase
    end
endmodule

// file: tm8_timer_regs.sv
// Purpose: 8-bit timer with compare outputs and flags on Avalon-MM
// Assumes: one wait state per access, aligned word addresses
// Notes: irq lines are per source, registered
`timescale 1ns/1ps
module tm8_timer_regs #(
    parameter int CNT_W = 8,
    parameter int PRE_W = 10
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    input  wire tm8_pkg::tm8_av_req_t avs_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire logic                 ext_count_pin_i,
    input  wire logic                 cpu_irq_enable_i,
    input  wire logic [2:0]           vec_ack_i,
    output logic                      wave_out_a_o,
    output logic                      wave_out_b_o,
    output logic [2:0]                irq_req_o
);
    if (CNT_W != 8) begin : g_chk
        $error("CNT_W must be 8");
    end

    // registers
    logic [7:0]        ctrl_a_r;
    logic              wm2_r;
    tm8_pkg::tm8_cs_t  cs_r;
    logic [7:0]        cnt_r;
    logic [7:0]        cnt_nxt;
    logic [7:0]        oca_r;
    logic [7:0]        ocb_r;
    logic [2:0]        mask_r;
    logic [2:0]        flag_r;
    logic [2:0]        flag_nxt;
    logic              up_r;
    logic              up_nxt;
    logic              block_r;
    logic              wa_nxt;
    logic              wb_nxt;
    logic [31:0]       rd_nxt;

    // bus decode
    wire logic [5:0]   idx;
    wire logic         take_rd;
    wire logic         fire_wr;
    wire logic [7:0]   wd;
    wire logic         wr_ca;
    wire logic         wr_cb;
    wire logic         wr_cnt;
    wire logic         wr_oca;
    wire logic         wr_ocb;
    wire logic         wr_msk;
    wire logic         wr_flg;

    assign idx     = avs_i.address[7:2];
    assign take_rd = avs_i.read & avs_waitrequest_o;
    assign fire_wr = avs_i.write & ~avs_waitrequest_o;
    assign wd      = avs_i.writedata[7:0];
    assign wr_ca   = fire_wr && idx == tm8_pkg::IDX_CTRL_A;
    assign wr_cb   = fire_wr && idx == tm8_pkg::IDX_CTRL_B;
    assign wr_cnt  = fire_wr && idx == tm8_pkg::IDX_COUNT;
    assign wr_oca  = fire_wr && idx == tm8_pkg::IDX_CMP_A;
    assign wr_ocb  = fire_wr && idx == tm8_pkg::IDX_CMP_B;
    assign wr_msk  = fire_wr && idx == tm8_pkg::IDX_MASK;
    assign wr_flg  = fire_wr && idx == tm8_pkg::IDX_FLAGS;

    // mode decode
    wire tm8_pkg::tm8_wm_t wm;
    wire logic       pc_mode;
    wire logic       fast_mode;
    wire logic       pwm;
    wire logic       top_oca;
    wire logic [7:0] top;
    wire logic [1:0] mode_a;
    wire logic [1:0] mode_b;

    assign wm        = tm8_pkg::tm8_wm_t'({wm2_r, ctrl_a_r[1:0]});
    assign pc_mode   = wm == tm8_pkg::WM_PC_FF || wm == tm8_pkg::WM_PC_OCA;
    assign fast_mode = wm == tm8_pkg::WM_FAST_FF || wm == tm8_pkg::WM_FAST_OCA;
    assign pwm       = pc_mode | fast_mode;
    assign top_oca   = wm == tm8_pkg::WM_CTC || wm == tm8_pkg::WM_PC_OCA
                       || wm == tm8_pkg::WM_FAST_OCA;
    assign top       = top_oca ? oca_r : tm8_pkg::CNT_MAX;
    assign mode_a    = ctrl_a_r[7:6];
    assign mode_b    = ctrl_a_r[5:4];

    // strobes and events
    wire logic tick;
    wire logic frc_a;
    wire logic frc_b;
    wire logic hit_a;
    wire logic hit_b;
    wire logic at_top;
    wire logic ovf;
    wire logic at_bot;

    tm8_tick_gen #(
        .PRE_W (PRE_W)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .cs_i       (cs_r),
        .pin_i      (ext_count_pin_i),
        .tick_o     (tick)
    );

    assign frc_a  = wr_cb & wd[tm8_pkg::BIT_FORCE_A] & ~pwm;
    assign frc_b  = wr_cb & wd[tm8_pkg::BIT_FORCE_B] & ~pwm;
    assign hit_a  = tick & ~block_r & ~wr_cnt & cnt_r == oca_r;
    assign hit_b  = tick & ~block_r & ~wr_cnt & cnt_r == ocb_r;
    assign at_top = cnt_r == top;
    assign at_bot = cnt_r == tm8_pkg::CNT_BOT;
    assign ovf    = tick & ~wr_cnt & (pc_mode ? (at_bot & ~up_r)
                    : (wm == tm8_pkg::WM_FAST_OCA ? at_top
                    : cnt_r == tm8_pkg::CNT_MAX));

    // counter sequence
    always_comb begin
        cnt_nxt = cnt_r;
        up_nxt  = up_r;
        if (wr_cnt) begin
            cnt_nxt = wd;
        end else if (tick) begin
            if (pc_mode) begin
                if (up_r && at_top) begin
                    up_nxt  = 1'b0;
                    cnt_nxt = cnt_r - 1'b1;
                end else if (!up_r && at_bot) begin
                    up_nxt  = 1'b1;
                    cnt_nxt = cnt_r + 1'b1;
                end else begin
                    cnt_nxt = up_r ? cnt_r + 1'b1 : cnt_r - 1'b1;
                end
            end else begin
                // forced compare never takes this wrap path
                cnt_nxt = at_top ? tm8_pkg::CNT_BOT : cnt_r + 1'b1;
            end
        end
    end

    // flags: hardware set wins over clear
    always_comb begin
        flag_nxt = flag_r & ~vec_ack_i;
        if (wr_flg) begin
            flag_nxt = flag_nxt & ~wd[2:0];
        end
        flag_nxt[tm8_pkg::BIT_CMPB] = flag_nxt[tm8_pkg::BIT_CMPB] | hit_b;
        flag_nxt[tm8_pkg::BIT_CMPA] = flag_nxt[tm8_pkg::BIT_CMPA] | hit_a;
        flag_nxt[tm8_pkg::BIT_OVF]  = flag_nxt[tm8_pkg::BIT_OVF] | ovf;
    end

    // waveform output for one channel
    function automatic logic wave_f(input logic cur, input logic [1:0] m,
                                    input logic hit, input logic frc,
                                    input logic tgl_ok);
        logic v;
        v = cur;
        if (!pwm) begin
            if (hit | frc) begin
                case (m)
                    2'b01:   v = ~cur;
                    2'b10:   v = 1'b0;
                    2'b11:   v = 1'b1;
                    default: v = cur;
                endcase
            end
        end else if (m == 2'b01) begin
            v = (hit & tgl_ok) ? ~cur : cur;
        end else if (m[1]) begin
            if (hit) begin
                v = pc_mode ? (m[0] ^ ~up_r) : m[0];
            end else if (fast_mode && tick && at_top) begin
                v = ~m[0];
            end
        end
        return v;
    endfunction

    // process form so that the mode and tick terms read inside wave_f wake it
    always_comb begin
        wa_nxt = wave_f(wave_out_a_o, mode_a, hit_a, frc_a, wm2_r);
        wb_nxt = wave_f(wave_out_b_o, mode_b, hit_b, frc_b, 1'b0);
    end

    // read mux
    always_comb begin
        rd_nxt = '0;
        case (idx)
            tm8_pkg::IDX_CTRL_A: rd_nxt[7:0] = ctrl_a_r & 8'hf3;
            tm8_pkg::IDX_CTRL_B: rd_nxt[7:0] = {4'h0, wm2_r, cs_r};
            tm8_pkg::IDX_COUNT:  rd_nxt[7:0] = cnt_r;
            tm8_pkg::IDX_CMP_A:  rd_nxt[7:0] = oca_r;
            tm8_pkg::IDX_CMP_B:  rd_nxt[7:0] = ocb_r;
            tm8_pkg::IDX_MASK:   rd_nxt[7:0] = {5'h00, mask_r};
            tm8_pkg::IDX_FLAGS:  rd_nxt[7:0] = {5'h00, flag_r};
            default:             rd_nxt = '0;
        endcase
    end

    // state
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_a_r          <= tm8_pkg::RST_VAL;
            wm2_r             <= 1'b0;
            cs_r              <= tm8_pkg::CS_STOP;
            cnt_r             <= tm8_pkg::RST_VAL;
            oca_r             <= tm8_pkg::RST_VAL;
            ocb_r             <= tm8_pkg::RST_VAL;
            mask_r            <= 3'h0;
            flag_r            <= 3'h0;
            up_r              <= 1'b1;
            block_r           <= 1'b0;
            wave_out_a_o      <= 1'b0;
            wave_out_b_o      <= 1'b0;
            irq_req_o         <= 3'h0;
            avs_readdata_o    <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            avs_waitrequest_o <= ~((avs_i.read | avs_i.write) & avs_waitrequest_o);
            if (take_rd) begin
                avs_readdata_o <= rd_nxt;
            end
            if (wr_ca) begin
                ctrl_a_r <= wd & 8'hf3;
            end
            if (wr_cb) begin
                wm2_r <= wd[tm8_pkg::BIT_WM2];
                cs_r  <= tm8_pkg::tm8_cs_t'(wd[2:0]);
            end
            if (wr_oca) begin
                oca_r <= wd;
            end
            if (wr_ocb) begin
                ocb_r <= wd;
            end
            if (wr_msk) begin
                mask_r <= wd[2:0];
            end
            if (wr_cnt) begin
                block_r <= 1'b1;
            end else if (tick) begin
                block_r <= 1'b0;
            end
            cnt_r        <= cnt_nxt;
            up_r         <= up_nxt;
            flag_r       <= flag_nxt;
            wave_out_a_o <= wa_nxt;
            wave_out_b_o <= wb_nxt;
            irq_req_o    <= flag_r & mask_r & {3{cpu_irq_enable_i}};
        end
    end

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_force_a;
        ce_i && frc_a && !hit_a && !vec_ack_i[1];
    endsequence

    chk_force_no_flag: assert property (
        (s_force_a and !flag_r[1]) |=> !flag_r[1])
        else $error("forced compare set a flag");

    chk_force_pwm_off: assert property (
        ce_i && wr_cb && pwm && !hit_a && !(fast_mode && tick && at_top)
        |=> $stable(wave_out_a_o))
        else $error("force acted in pwm mode");

    chk_force_set: assert property (
        (s_force_a and mode_a == 2'b11) |=> wave_out_a_o)
        else $error("force did not set output");

    chk_flag_w1c: assert property (
        ce_i && wr_flg && wd[0] && !ovf |=> !flag_r[0])
        else $error("flag not cleared by one");

    chk_flag_set_wins: assert property (
        ce_i && hit_b |=> flag_r[2])
        else $error("compare b match lost");

    chk_cnt_block: assert property (
        ce_i && wr_cnt |=> block_r && !hit_a && !hit_b)
        else $error("compare not blocked after count write");

    chk_stop_hold: assert property (
        ce_i && cs_r == tm8_pkg::CS_STOP && !wr_cnt ##1 ce_i
        |-> cnt_r == $past(cnt_r))
        else $error("stopped counter moved");

    chk_irq_gate: assert property (
        ce_i && !cpu_irq_enable_i |=> irq_req_o == 3'h0)
        else $error("irq without global enable");

    chk_rsv_zero: assert property (
        ce_i && take_rd && idx == tm8_pkg::IDX_CTRL_B |=> avs_readdata_o[7:4] == 4'h0)
        else $error("reserved or force bits read nonzero");

    chk_ack_clear: assert property (
        ce_i && vec_ack_i[0] && !ovf |=> !flag_r[0])
        else $error("vector did not clear flag");

    chk_ovf_normal: assert property (
        ce_i && wm == tm8_pkg::WM_NORMAL && tick && !wr_cnt && cnt_r == 8'hff
        |=> flag_r[0] && cnt_r == 8'h00)
        else $error("normal overflow missed");
endmodule

// file: tm8_timer_regs_tb_top.sv
// Purpose: self-checking bench for the 8-bit timer register block
// Assumes: Avalon-MM slave with waitrequest, one clock domain
// Notes: external pin and vector acknowledges driven by the bench
`timescale 1ns/1ps
module tm8_timer_regs_tb_top;
    logic                 core_clk_i;
    logic                 rst_n_i;
    logic                 ce;
    tm8_pkg::tm8_av_req_t avs;
    logic [31:0]          rdata;
    logic                 wait_req;
    logic                 pin;
    logic                 irq_en;
    logic [2:0]           vec_ack;
    logic                 wave_a;
    logic                 wave_b;
    logic [2:0]           irq_req;
    int                   n_fail;
    int                   n_tests;
    localparam logic [7:0] A_CA  = {tm8_pkg::IDX_CTRL_A, 2'b00};
    localparam logic [7:0] A_CB  = {tm8_pkg::IDX_CTRL_B, 2'b00};
    localparam logic [7:0] A_CNT = {tm8_pkg::IDX_COUNT, 2'b00};
    localparam logic [7:0] A_OCA = {tm8_pkg::IDX_CMP_A, 2'b00};
    localparam logic [7:0] A_OCB = {tm8_pkg::IDX_CMP_B, 2'b00};
    localparam logic [7:0] A_MSK = {tm8_pkg::IDX_MASK, 2'b00};
    localparam logic [7:0] A_FLG = {tm8_pkg::IDX_FLAGS, 2'b00};

    tm8_timer_regs tm8_timer_regs_inst (
        .core_clk_i        (core_clk_i),
        .rst_n_i           (rst_n_i),
        .ce_i              (ce),
        .avs_i             (avs),
        .avs_readdata_o    (rdata),
        .avs_waitrequest_o (wait_req),
        .ext_count_pin_i   (pin),
        .cpu_irq_enable_i  (irq_en),
        .vec_ack_i         (vec_ack),
        .wave_out_a_o      (wave_a),
        .wave_out_b_o      (wave_b),
        .irq_req_o         (irq_req)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one bus access, held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int k;
        @(posedge core_clk_i);
        avs.read <= ~is_wr;
        avs.write <= is_wr;
        avs.address <= a;
        avs.writedata <= {24'h000000, d};
        for (k = 0; k < 50; k++) begin
            @(posedge core_clk_i);
            if (wait_req === 1'b0) break;
        end
        if (k < 50) begin
            q = rdata[7:0];
            avs.read <= 1'b0;
            avs.write <= 1'b0;
        end else begin
            n_fail++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(nm, q & m, exp);
    endtask

    // pin pulses long enough for the synchroniser and edge detector
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (6) @(posedge core_clk_i);
            pin <= 1'b1;
            repeat (6) @(posedge core_clk_i);
            pin <= 1'b0;
        end
        repeat (6) @(posedge core_clk_i);
    endtask

    initial begin
        logic [7:0] addrs[8];
        int         divs[5];
        int         i;
        int         w;
        logic [7:0] q;
        logic       ok;
        addrs = '{A_CA, A_CB, A_CNT, A_OCA, A_OCB, A_MSK, A_FLG, 8'h00};
        divs = '{1, 8, 64, 256, 1024};
        n_fail = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        avs = '0;
        pin = 1'b0;
        ce = 1'b1;
        irq_en = 1'b0;
        vec_ack = 3'b000;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        // reset values, unmapped address last
        for (i = 0; i < 8; i++) rd("reset value", addrs[i], 8'hff, 8'h00);
        chk("wave outs", {6'h00, wave_a, wave_b}, 8'h00);
        $display("test reset done");
        wr(A_CB, 8'h38);
        rd("control b", A_CB, 8'hff, 8'h08);
        wr(A_CB, 8'h00);
        wr(A_MSK, 8'hff);
        rd("irq mask", A_MSK, 8'hff, 8'h07);
        rd("irq flags", A_FLG, 8'hff, 8'h00);
        $display("test reserved done");
        // toggle mode, clear-on-match with compare a equal to count
        wr(A_CA, 8'h52);
        wr(A_OCA, 8'h05);
        wr(A_CNT, 8'h05);
        wr(A_CB, 8'hc0);
        @(negedge core_clk_i);
        chk("forced outs", {6'h00, wave_a, wave_b}, 8'h03);
        rd("strobe bits", A_CB, 8'hff, 8'h00);
        rd("forced flags", A_FLG, 8'hff, 8'h00);
        rd("forced count", A_CNT, 8'hff, 8'h05);
        wr(A_CA, 8'ha3);
        wr(A_CB, 8'hc0);
        @(negedge core_clk_i);
        chk("pwm force", {6'h00, wave_a, wave_b}, 8'h03);
        wr(A_CA, 8'ha0);
        wr(A_CB, 8'hc0);
        @(negedge core_clk_i);
        chk("clear force", {6'h00, wave_a, wave_b}, 8'h00);
        wr(A_CA, 8'hf0);
        wr(A_CB, 8'hc0);
        @(negedge core_clk_i);
        chk("set force", {6'h00, wave_a, wave_b}, 8'h03);
        $display("test force done");
        wr(A_CA, 8'h00);
        wr(A_CB, 8'h07);
        wr(A_OCA, 8'h10);
        wr(A_CNT, 8'h10);
        wr(A_FLG, 8'h07);
        pulses(1);
        rd("rise count", A_CNT, 8'hff, 8'h11);
        rd("blocked match", A_FLG, 8'h02, 8'h00);
        wr(A_OCA, 8'h11);
        pulses(1);
        rd("pin match", A_FLG, 8'h02, 8'h02);
        wr(A_CB, 8'h06);
        wr(A_CNT, 8'h00);
        pulses(3);
        rd("fall count", A_CNT, 8'hff, 8'h03);
        wr(A_CA, 8'h03);
        wr(A_OCA, 8'h03);
        wr(A_CNT, 8'h02);
        wr(A_CB, 8'h0f);
        wr(A_FLG, 8'h07);
        pulses(2);
        rd("top wrap", A_CNT, 8'hff, 8'h00);
        rd("top overflow", A_FLG, 8'h01, 8'h01);
        // phase-correct with compare a as top, overflow when turning at bottom
        wr(A_CA, 8'h01);
        wr(A_CNT, 8'h02);
        wr(A_FLG, 8'h07);
        pulses(4);
        rd("phase down", A_CNT, 8'hff, 8'h00);
        rd("phase no overflow", A_FLG, 8'h01, 8'h00);
        pulses(1);
        rd("phase up", A_CNT, 8'hff, 8'h01);
        rd("phase overflow", A_FLG, 8'h01, 8'h01);
        $display("test pin done");
        wr(A_CA, 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(A_CB, 8'h00);
            wr(A_CNT, 8'h00);
            w = divs[i] * 4 + 40;
            wr(A_CB, 8'(i + 1));
            repeat (w) @(posedge core_clk_i);
            wr(A_CB, 8'h00);
            acc(1'b0, A_CNT, 8'h00, q);
            ok = (q >= 8'(w / divs[i] - 1)) && (q <= 8'((w + 10) / divs[i] + 1));
            chk("prescale count", {7'h00, ok}, 8'h01);
        end
        $display("test prescale done");
        wr(A_OCA, 8'h10);
        wr(A_OCB, 8'h20);
        wr(A_CNT, 8'h00);
        wr(A_FLG, 8'h07);
        irq_en <= 1'b1;
        wr(A_CB, 8'h01);
        repeat (60) @(posedge core_clk_i);
        rd("match flags", A_FLG, 8'hff, 8'h06);
        chk("irq both", {5'h00, irq_req}, 8'h06);
        wr(A_FLG, 8'h02);
        rd("clear one", A_FLG, 8'hff, 8'h04);
        wr(A_FLG, 8'h00);
        rd("write zero", A_FLG, 8'hff, 8'h04);
        chk("irq b", {5'h00, irq_req}, 8'h04);
        irq_en <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk("irq global off", {5'h00, irq_req}, 8'h00);
        vec_ack <= 3'b111;
        @(posedge core_clk_i);
        vec_ack <= 3'b000;
        rd("vector clear", A_FLG, 8'hff, 8'h00);
        wr(A_CNT, 8'hf0);
        repeat (30) @(posedge core_clk_i);
        rd("max overflow", A_FLG, 8'h01, 8'h01);
        // clock enable low for 20 edges freezes the undivided count
        wr(A_CNT, 8'h00);
        ce <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        ce <= 1'b1;
        rd("frozen count", A_CNT, 8'hff, 8'h01);
        $display("test irq done");
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge core_clk_i);
        n_fail++;
        stop_test();
    end
endmodule
